// *** verilog/cec_pkg.sv ***
/*
  constants for the cache error control register bank: offsets, field
  positions, reset values, status bit positions.
  assumes a 32-bit avalon-mm slave with byte addresses.
*/
package cec_pkg;
  localparam int          ADDR_W        = 4;
  localparam int          DATA_W        = 32;
  localparam logic [3:0]  OFF_CTRL      = 4'h0;
  localparam logic [3:0]  OFF_IRQ_STAT  = 4'h4;
  localparam logic [3:0]  OFF_IRQ_MASK  = 4'h8;
  // field positions in cache_error_control
  localparam int          BIT_PE        = 31;
  localparam int          BIT_LBE       = 25;
  localparam int          BIT_WRITE_ALLOCATE_BUS_ERROR_FLAG      = 24;
  localparam int          BIT_L2P       = 23;
  localparam int          BIT_DBL       = 20;
  localparam int          BIT_INIT      = 19;
  localparam int          PRE_LSB       = 13;
  localparam int          PRE_W         = 6;
  localparam int          IPAR_LSB      = 4;
  localparam int          IPAR_W        = 9;
  localparam int          DPAR_LSB      = 0;
  localparam int          DPAR_W        = 4;
  // interrupt status bits
  localparam int          IRQ_W         = 4;
  localparam int          IRQ_FIRST     = 0;
  localparam int          IRQ_SECOND    = 1;
  localparam int          IRQ_LOAD_BE   = 2;
  localparam int          IRQ_WA_BE     = 3;
  // reset values
  localparam logic        RST_BIT       = 1'b0;
  localparam logic [5:0]  RST_PRE       = 6'h00;
  localparam logic [8:0]  RST_IPAR      = 9'h000;
  localparam logic [3:0]  RST_DPAR      = 4'h0;
  localparam logic [3:0]  RST_IRQ       = 4'h0;
  localparam logic [31:0] RST_RDATA     = 32'h0000_0000;
endpackage

// *** verilog/cec_byte_par.sv ***
/*
  per-byte even parity generator.
  assumes the caller registers the result where timing needs it.
*/
`timescale 1ns/1ps
module cec_byte_par #(
  parameter int BYTES = 8
) (
  // data in
  input  wire logic [8*BYTES-1:0] i_data,
  // parity out, one bit per byte
  output logic      [BYTES-1:0]   o_par
);
  genvar g;
  generate
    for (g = 0; g < BYTES; g = g + 1)
    begin : g_byte
      // even parity: bit makes the byte plus parity hold an even count
      assign o_par[g] = ^i_data[8*g +: 8];
    end
  endgenerate
endmodule

// *** verilog/cec_err_track.sv ***
/*
  first/second cache error tracker.
  assumes i_err is a one-cycle pulse on i_clk_sys from the checkers.
*/
`timescale 1ns/1ps
module cec_err_track (
  // clock and reset
  input  wire logic i_clk_sys,
  input  wire logic i_srst,
  // error event and software write
  input  wire logic i_err,
  input  wire logic i_sw_wr,
  input  wire logic i_sw_val,
  // state and events
  output logic      o_init,
  output logic      o_dbl,
  output logic      o_first_evt,
  output logic      o_second_evt
);
  logic init_r;
  logic dbl_r;
  logic init_nxt;
  logic dbl_nxt;

  assign o_first_evt  = i_err & ~init_r;
  assign o_second_evt = i_err & init_r;
  // an error in the same cycle as a software clear still counts
  assign init_nxt = i_err ? 1'b1 : (i_sw_wr ? i_sw_val : init_r);
  assign dbl_nxt  = i_err ? init_r : dbl_r;

  always_ff @(posedge i_clk_sys)
  begin
    if (i_srst)
    begin
      init_r <= cec_pkg::RST_BIT;
      dbl_r  <= cec_pkg::RST_BIT;
    end
    else
    begin
      init_r <= init_nxt;
      dbl_r  <= dbl_nxt;
    end
  end

  assign o_init = init_r;
  assign o_dbl  = dbl_r;
endmodule

// *** verilog/cec_top.sv ***
/*
  cache error control register bank (lower fields plus parity enable),
  with sticky interrupt status and mask, behind an avalon-mm slave.
  assumes bus error, checker and cache ram read inputs come from logic
  on i_clk_sys; error and read strobes are one-cycle pulses.
*/
// The register offsets and register access over Avalon-MM were chosen for this implementation.
// Operation
// - the write-allocate bus error flag (bit 24) shows the latest bus error lost store data.
// - load and write-allocate bus error flags may both be set by one bus error.
// - the l2 protection toggle (bit 23) resets to 0 and is settable only with ecc-capable l2.
// - l2 ecc checking is on exactly when parity enable and l2 protection toggle differ.
// - bits 22 to 21 always read as zero.
// - the double fault flag (bit 20) sets on a cache error while the initial flag is set.
// - the double fault flag clears on reset and on a cache error with the initial flag clear.
// - the initial error flag (bit 19) is read/write and clears on reset.
// - bits 18 to 13 hold the instruction precode bits for the icache data ram.
// - bits 12 to 4 hold icache parity: bit 12 over precode, bits 11 to 4 per data byte.
// - bits 3 to 0 hold dcache data parity, bit 0 for the least significant byte.
// - parity enable (bit 31) is writable only when parity is built, else reads 0.
// - the load bus error flag (bit 25) shows the latest bus error involved a load.
`timescale 1ns/1ps
module cec_top #(
  parameter bit PARITY_BUILT   = 1'b1,
  parameter bit L2_ECC_CAPABLE = 1'b1
) (
  // clock and reset
  input  wire logic        i_clk_sys,
  input  wire logic        i_srst,
  // avalon-mm slave
  input  wire logic [3:0]  i_avs_address,
  input  wire logic        i_avs_read,
  input  wire logic        i_avs_write,
  input  wire logic [31:0] i_avs_writedata,
  input  wire logic [3:0]  i_avs_byteenable,
  output logic      [31:0] o_avs_readdata,
  output logic             o_avs_waitrequest,
  // bus error logic
  input  wire logic        i_bus_err,
  input  wire logic        i_bus_err_load,
  input  wire logic        i_bus_err_wa,
  // cache parity checkers
  input  wire logic        i_cache_err,
  // icache data ram read
  input  wire logic        i_iram_rd_valid,
  input  wire logic [63:0] i_iram_rd_data,
  input  wire logic [5:0]  i_iram_rd_precode,
  input  wire logic [8:0]  i_iram_rd_parity,
  // dcache data ram read
  input  wire logic        i_dram_rd_valid,
  input  wire logic [31:0] i_dram_rd_data,
  input  wire logic [3:0]  i_dram_rd_parity,
  // control and state to the caches
  output logic             o_parity_enable,
  output logic             o_l2_ecc_check,
  output logic      [5:0]  o_precode,
  output logic      [8:0]  o_icache_parity,
  output logic      [3:0]  o_dcache_parity,
  output logic             o_double_fault,
  output logic             o_irq
);
  // byte-enable to bit mask, used by every writable register
  function automatic logic [31:0] be_mask(input logic [3:0] be);
    logic [31:0] m;
    m = 32'h0000_0000;
    for (int i = 0; i < 4; i++)
    begin
      m[8*i +: 8] = be[i] ? 8'hff : 8'h00;
    end
    return m;
  endfunction

  // registers
  logic        wait_r;
  logic [31:0] rdata_r;
  logic        pe_r;
  logic        l2p_r;
  logic        l2chk_r;
  logic        lbe_r;
  logic        write_allocate_bus_error_flag_r;
  logic [5:0]  pre_r;
  logic [8:0]  ipar_r;
  logic [3:0]  dpar_r;
  logic [3:0]  stat_r;
  logic [3:0]  mask_r;
  logic        irq_r;
  logic        dbl_r;

  // next values
  logic        wait_nxt;
  logic [31:0] rdata_nxt;
  logic        pe_nxt;
  logic        l2p_nxt;
  logic        lbe_nxt;
  logic        write_allocate_bus_error_flag_nxt;
  logic [5:0]  pre_nxt;
  logic [8:0]  ipar_nxt;
  logic [3:0]  dpar_nxt;
  logic [3:0]  stat_nxt;
  logic [3:0]  mask_nxt;

  // bus decode
  wire         wr_done;
  wire         rd_take;
  wire         sel_ctrl;
  wire         sel_stat;
  wire         sel_mask;
  wire         ctrl_wr;
  wire         stat_wr;
  wire         mask_wr;
  wire [31:0]  wmask;
  wire [31:0]  ctrl_rd;
  wire [31:0]  ctrl_wval;
  wire [31:0]  rd_mux;

  // error tracking
  wire         init_w;
  wire         dbl_w;
  wire         first_evt;
  wire         second_evt;
  wire         err_evt;
  wire [7:0]   ibyte_par;
  wire [3:0]   dbyte_par;
  wire [8:0]   icalc;
  wire         iram_bad;
  wire         dram_bad;
  wire [3:0]   evt;
  wire [3:0]   clr;

  // one wait cycle per access: waitrequest drops for exactly one edge
  assign wait_nxt  = ~((i_avs_read | i_avs_write) & wait_r);
  assign wr_done   = i_avs_write & ~wait_r;
  assign rd_take   = i_avs_read & wait_r;

  assign sel_ctrl  = (i_avs_address == cec_pkg::OFF_CTRL);
  assign sel_stat  = (i_avs_address == cec_pkg::OFF_IRQ_STAT);
  assign sel_mask  = (i_avs_address == cec_pkg::OFF_IRQ_MASK);
  assign ctrl_wr   = wr_done & sel_ctrl;
  assign stat_wr   = wr_done & sel_stat;
  assign mask_wr   = wr_done & sel_mask;
  assign wmask     = be_mask(i_avs_byteenable);

  // upper control bits live elsewhere and read as zero here
  assign ctrl_rd = {pe_r, 5'h00, lbe_r, write_allocate_bus_error_flag_r, l2p_r,
                    2'b00,
                    dbl_w, init_w, pre_r, ipar_r, dpar_r};
  assign ctrl_wval = (ctrl_rd & ~wmask) | (i_avs_writedata & wmask);

  // unmapped addresses read as zero and ignore writes
  assign rd_mux = sel_ctrl ? ctrl_rd :
                  sel_stat ? {28'h0000000, stat_r} :
                  sel_mask ? {28'h0000000, mask_r} :
                  32'h0000_0000;
  assign rdata_nxt = rd_take ? rd_mux : rdata_r;

  // parity checks on cache ram reads, only while parity is enabled
  cec_byte_par #(
    .BYTES (8)
  ) u_ipar (
    .i_data (i_iram_rd_data),
    .o_par  (ibyte_par)
  );

  cec_byte_par #(
    .BYTES (4)
  ) u_dpar (
    .i_data (i_dram_rd_data),
    .o_par  (dbyte_par)
  );

  assign icalc    = {^i_iram_rd_precode, ibyte_par};
  assign iram_bad = pe_r & i_iram_rd_valid & (icalc != i_iram_rd_parity);
  assign dram_bad = pe_r & i_dram_rd_valid & (dbyte_par != i_dram_rd_parity);
  assign err_evt  = i_cache_err | iram_bad | dram_bad;

  cec_err_track u_track (
    .i_clk_sys    (i_clk_sys),
    .i_srst       (i_srst),
    .i_err        (err_evt),
    .i_sw_wr      (ctrl_wr),
    .i_sw_val     (ctrl_wval[cec_pkg::BIT_INIT]),
    .o_init       (init_w),
    .o_dbl        (dbl_w),
    .o_first_evt  (first_evt),
    .o_second_evt (second_evt)
  );

  // control field next values
  assign pe_nxt  = (ctrl_wr & PARITY_BUILT) ? ctrl_wval[cec_pkg::BIT_PE] : pe_r;
  assign l2p_nxt = (ctrl_wr & L2_ECC_CAPABLE) ? ctrl_wval[cec_pkg::BIT_L2P] : l2p_r;

  // each bus error replaces both flags; both may come up together
  assign lbe_nxt  = i_bus_err ? i_bus_err_load : lbe_r;
  assign write_allocate_bus_error_flag_nxt = i_bus_err ? i_bus_err_wa : write_allocate_bus_error_flag_r;

  // a ram read in the same cycle as a software write wins
  assign pre_nxt  = i_iram_rd_valid ? i_iram_rd_precode :
                    ctrl_wr ? ctrl_wval[cec_pkg::PRE_LSB +: cec_pkg::PRE_W] :
                    pre_r;
  assign ipar_nxt = i_iram_rd_valid ? i_iram_rd_parity :
                    ctrl_wr ? ctrl_wval[cec_pkg::IPAR_LSB +: cec_pkg::IPAR_W] :
                    ipar_r;
  assign dpar_nxt = i_dram_rd_valid ? i_dram_rd_parity :
                    ctrl_wr ? ctrl_wval[cec_pkg::DPAR_LSB +: cec_pkg::DPAR_W] :
                    dpar_r;

  // sticky status, write one to clear; a new event beats the clear
  assign evt[cec_pkg::IRQ_FIRST]   = first_evt;
  assign evt[cec_pkg::IRQ_SECOND]  = second_evt;
  assign evt[cec_pkg::IRQ_LOAD_BE] = i_bus_err & i_bus_err_load;
  assign evt[cec_pkg::IRQ_WA_BE]   = i_bus_err & i_bus_err_wa;
  assign clr      = stat_wr ? (i_avs_writedata[3:0] & wmask[3:0]) : 4'h0;
  assign stat_nxt = (stat_r & ~clr) | evt;
  assign mask_nxt = mask_wr ? ((mask_r & ~wmask[3:0]) | (i_avs_writedata[3:0] & wmask[3:0]))
                            : mask_r;

  // bus slave registers
  always_ff @(posedge i_clk_sys)
  begin
    if (i_srst)
    begin
      wait_r  <= 1'b1;
      rdata_r <= cec_pkg::RST_RDATA;
    end
    else
    begin
      wait_r  <= wait_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // control bits
  always_ff @(posedge i_clk_sys)
  begin
    if (i_srst)
    begin
      pe_r    <= cec_pkg::RST_BIT;
      l2p_r   <= cec_pkg::RST_BIT;
      l2chk_r <= cec_pkg::RST_BIT;
      dbl_r   <= cec_pkg::RST_BIT;
    end
    else
    begin
      pe_r    <= pe_nxt;
      l2p_r   <= l2p_nxt;
      l2chk_r <= pe_nxt ^ l2p_nxt;
      dbl_r   <= dbl_w;
    end
  end

  // bus error flags; undefined after reset, cleared for determinism
  always_ff @(posedge i_clk_sys)
  begin
    if (i_srst)
    begin
      lbe_r  <= cec_pkg::RST_BIT;
      write_allocate_bus_error_flag_r <= cec_pkg::RST_BIT;
    end
    else
    begin
      lbe_r  <= lbe_nxt;
      write_allocate_bus_error_flag_r <= write_allocate_bus_error_flag_nxt;
    end
  end

  // precode and parity fields
  always_ff @(posedge i_clk_sys)
  begin
    if (i_srst)
    begin
      pre_r  <= cec_pkg::RST_PRE;
      ipar_r <= cec_pkg::RST_IPAR;
      dpar_r <= cec_pkg::RST_DPAR;
    end
    else
    begin
      pre_r  <= pre_nxt;
      ipar_r <= ipar_nxt;
      dpar_r <= dpar_nxt;
    end
  end

  // interrupt status, mask and output
  always_ff @(posedge i_clk_sys)
  begin
    if (i_srst)
    begin
      stat_r <= cec_pkg::RST_IRQ;
      mask_r <= cec_pkg::RST_IRQ;
      irq_r  <= cec_pkg::RST_BIT;
    end
    else
    begin
      stat_r <= stat_nxt;
      mask_r <= mask_nxt;
      irq_r  <= |(stat_nxt & mask_nxt);
    end
  end

  // double fault output follows the tracker flop, one flop later
  assign o_avs_readdata    = rdata_r;
  assign o_avs_waitrequest = wait_r;
  assign o_parity_enable   = pe_r;
  assign o_l2_ecc_check    = l2chk_r;
  assign o_precode         = pre_r;
  assign o_icache_parity   = ipar_r;
  assign o_dcache_parity   = dpar_r;
  assign o_double_fault    = dbl_r;
  assign o_irq             = irq_r;
endmodule

// *** verification/cec_properties.sv ***
/*
  port checker for cec_top, bound into every instance.
  assumes one clock domain and the fixed one-wait-cycle slave.
*/
`timescale 1ns/1ps
module cec_props #(
  parameter bit PARITY_BUILT = 1'b1
) (
  input wire logic        i_clk_sys,
  input wire logic        i_srst,
  input wire logic [3:0]  i_avs_address,
  input wire logic        i_avs_read,
  input wire logic        i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0]  i_avs_byteenable,
  input wire logic [31:0] o_avs_readdata,
  input wire logic        o_avs_waitrequest,
  input wire logic        i_cache_err,
  input wire logic        i_iram_rd_valid,
  input wire logic [5:0]  i_iram_rd_precode,
  input wire logic [8:0]  i_iram_rd_parity,
  input wire logic        i_dram_rd_valid,
  input wire logic [3:0]  i_dram_rd_parity,
  input wire logic        o_parity_enable,
  input wire logic        o_l2_ecc_check,
  input wire logic [5:0]  o_precode,
  input wire logic [8:0]  o_icache_parity,
  input wire logic [3:0]  o_dcache_parity,
  input wire logic        o_double_fault,
  input wire logic        o_irq
);
  wire ctrl_acc = !o_avs_waitrequest && i_avs_address == 4'h0;
  wire ctrl_rd  = ctrl_acc && i_avs_read;
  wire ctrl_wr  = ctrl_acc && i_avs_write;
  // ram reads may raise an internal cache error, so they spoil quiet
  wire quiet    = !i_cache_err && !i_iram_rd_valid && !i_dram_rd_valid;
  default clocking dc @(posedge i_clk_sys);
  endclocking
  default disable iff (i_srst);
  sequence s_two_err;
    i_cache_err ##1 i_cache_err;
  endsequence
  sequence s_init_clr;
    (ctrl_wr && i_avs_byteenable[2] && !i_avs_writedata[19] && quiet)
      ##1 (quiet && !ctrl_wr) ##1 (i_cache_err && !i_iram_rd_valid && !i_dram_rd_valid);
  endsequence
  a_rst_idle: assert property ($fell(i_srst) |-> o_avs_waitrequest && !o_irq
    && !o_double_fault && !o_l2_ecc_check && o_avs_readdata == 32'h0)
    else $error("not idle after reset");
  a_ecc_xor: assert property (ctrl_rd |->
    o_l2_ecc_check == (o_avs_readdata[31] ^ o_avs_readdata[23]))
    else $error("l2 check not xor");
  a_zero_bits: assert property (ctrl_rd |-> o_avs_readdata[22:21] == 2'h0)
    else $error("reserved bits set");
  a_par_gate: assert property (ctrl_rd |-> o_avs_readdata[31] == o_parity_enable
    && (PARITY_BUILT || !o_parity_enable))
    else $error("parity enable wrong");
  a_double_set: assert property (s_two_err |-> ##2 o_double_fault)
    else $error("double fault missed");
  a_double_clr: assert property (s_init_clr |-> ##2 !o_double_fault)
    else $error("double fault not cleared");
  a_wait_one: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest
    |=> !o_avs_waitrequest ##1 o_avs_waitrequest)
    else $error("wait cycle count wrong");
  a_iram_load: assert property (i_iram_rd_valid |=> o_precode == $past(i_iram_rd_precode)
    && o_icache_parity == $past(i_iram_rd_parity))
    else $error("icache fields not loaded");
  a_dram_load: assert property (i_dram_rd_valid |=>
    o_dcache_parity == $past(i_dram_rd_parity))
    else $error("dcache field not loaded");
endmodule
bind cec_top cec_props #(
  .PARITY_BUILT (PARITY_BUILT)
) u_props (
  .i_clk_sys         (i_clk_sys),
  .i_srst            (i_srst),
  .i_avs_address     (i_avs_address),
  .i_avs_read        (i_avs_read),
  .i_avs_write       (i_avs_write),
  .i_avs_writedata   (i_avs_writedata),
  .i_avs_byteenable  (i_avs_byteenable),
  .o_avs_readdata    (o_avs_readdata),
  .o_avs_waitrequest (o_avs_waitrequest),
  .i_cache_err       (i_cache_err),
  .i_iram_rd_valid   (i_iram_rd_valid),
  .i_iram_rd_precode (i_iram_rd_precode),
  .i_iram_rd_parity  (i_iram_rd_parity),
  .i_dram_rd_valid   (i_dram_rd_valid),
  .i_dram_rd_parity  (i_dram_rd_parity),
  .o_parity_enable   (o_parity_enable),
  .o_l2_ecc_check    (o_l2_ecc_check),
  .o_precode         (o_precode),
  .o_icache_parity   (o_icache_parity),
  .o_dcache_parity   (o_dcache_parity),
  .o_double_fault    (o_double_fault),
  .o_irq             (o_irq)
);

// *** verification/cec_err_src.sv ***
/*
  model of the cache checkers, bus error logic and cache ram reads.
  assumes the bench calls its tasks one at a time.
*/
`timescale 1ns/1ps
module cec_err_src (
  input  wire logic        i_clk_sys,
  output logic             o_bus_err,
  output logic             o_bus_ld,
  output logic             o_bus_wa,
  output logic             o_cache_err,
  output logic             o_iv,
  output logic      [63:0] o_id,
  output logic      [5:0]  o_ip,
  output logic      [8:0]  o_ipar,
  output logic             o_dv,
  output logic      [31:0] o_dd,
  output logic      [3:0]  o_dpar
);
  initial
  begin
    {o_bus_err, o_bus_ld, o_bus_wa, o_cache_err, o_iv, o_dv} = 6'h00;
    {o_id, o_ip, o_ipar, o_dd, o_dpar} = '0;
  end
  function automatic logic [7:0] par8(input logic [63:0] d);
    for (int i = 0; i < 8; i++)
      par8[i] = ^d[8*i+:8];
  endfunction
  // qualifiers and ram data mean nothing outside the pulse: invert them
  task automatic berr(input logic ld, input logic wa);
    @(posedge i_clk_sys);
    o_bus_err <= 1'b1;
    o_bus_ld <= ld;
    o_bus_wa <= wa;
    @(posedge i_clk_sys);
    o_bus_err <= 1'b0;
    o_bus_ld <= ~ld;
    o_bus_wa <= ~wa;
  endtask
  task automatic cerr(input int n);
    @(posedge i_clk_sys);
    o_cache_err <= 1'b1;
    repeat (n) @(posedge i_clk_sys);
    o_cache_err <= 1'b0;
  endtask
  task automatic iread(input logic [5:0] p, input logic [63:0] d);
    @(posedge i_clk_sys);
    o_iv <= 1'b1;
    o_ip <= p;
    o_id <= d;
    o_ipar <= {^p, par8(d)};
    @(posedge i_clk_sys);
    o_iv <= 1'b0;
    o_ip <= ~p;
    o_id <= ~d;
  endtask
  task automatic dread(input logic [31:0] d, input logic bad);
    @(posedge i_clk_sys);
    o_dv <= 1'b1;
    o_dd <= d;
    o_dpar <= 4'(par8({32'h0, d})) ^ {3'h0, bad};
    @(posedge i_clk_sys);
    o_dv <= 1'b0;
    o_dd <= ~d;
  endtask
endmodule

// *** verification/testbench.sv ***
/*
  self-checking bench for cec_top with the checker model.
  assumes default parameters: parity built, l2 ecc capable.
*/
`timescale 1ns/1ps
module testbench;
  logic        i_clk_sys = 1'b0;
  logic        i_srst = 1'b1;
  logic [3:0]  i_avs_address = 4'h0;
  logic        i_avs_read = 1'b0;
  logic        i_avs_write = 1'b0;
  logic [31:0] i_avs_writedata = 32'h0;
  logic [3:0]  i_avs_byteenable = 4'hf;
  wire logic [31:0] o_avs_readdata, i_dram_rd_data;
  wire logic [63:0] i_iram_rd_data;
  wire logic [8:0]  i_iram_rd_parity, o_icache_parity;
  wire logic [5:0]  i_iram_rd_precode, o_precode;
  wire logic [3:0]  i_dram_rd_parity, o_dcache_parity;
  wire logic o_avs_waitrequest, i_bus_err, i_bus_err_load, i_bus_err_wa, i_cache_err;
  wire logic i_iram_rd_valid, i_dram_rd_valid, o_parity_enable, o_l2_ecc_check;
  wire logic o_double_fault, o_irq;
  int fail_count = 0;
  int total_checks = 0;
  cec_top dut (
    .i_clk_sys (i_clk_sys), .i_srst (i_srst),
    .i_avs_address (i_avs_address), .i_avs_read (i_avs_read),
    .i_avs_write (i_avs_write), .i_avs_writedata (i_avs_writedata),
    .i_avs_byteenable (i_avs_byteenable), .o_avs_readdata (o_avs_readdata),
    .o_avs_waitrequest (o_avs_waitrequest), .i_bus_err (i_bus_err),
    .i_bus_err_load (i_bus_err_load), .i_bus_err_wa (i_bus_err_wa),
    .i_cache_err (i_cache_err), .i_iram_rd_valid (i_iram_rd_valid),
    .i_iram_rd_data (i_iram_rd_data), .i_iram_rd_precode (i_iram_rd_precode),
    .i_iram_rd_parity (i_iram_rd_parity), .i_dram_rd_valid (i_dram_rd_valid),
    .i_dram_rd_data (i_dram_rd_data), .i_dram_rd_parity (i_dram_rd_parity),
    .o_parity_enable (o_parity_enable), .o_l2_ecc_check (o_l2_ecc_check),
    .o_precode (o_precode), .o_icache_parity (o_icache_parity),
    .o_dcache_parity (o_dcache_parity), .o_double_fault (o_double_fault),
    .o_irq (o_irq)
  );
  cec_err_src u_src (.i_clk_sys(i_clk_sys), .o_bus_err(i_bus_err),
    .o_bus_ld(i_bus_err_load), .o_bus_wa(i_bus_err_wa), .o_cache_err(i_cache_err),
    .o_iv(i_iram_rd_valid), .o_id(i_iram_rd_data), .o_ip(i_iram_rd_precode),
    .o_ipar(i_iram_rd_parity), .o_dv(i_dram_rd_valid), .o_dd(i_dram_rd_data),
    .o_dpar(i_dram_rd_parity));
  initial
  begin
    forever #4 i_clk_sys = ~i_clk_sys;
  end
  function automatic logic [7:0] ep(input logic [63:0] d);
    for (int i = 0; i < 8; i++)
      ep[i] = ^d[8*i+:8];
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // the slave answers after a fixed one-cycle wait; only the watchdog ends a hang
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge i_clk_sys);
    i_avs_address <= a;
    i_avs_writedata <= d;
    i_avs_write <= w;
    i_avs_read <= !w;
    @(posedge i_clk_sys);
    while (o_avs_waitrequest !== 1'b0)
      @(posedge i_clk_sys);
    q = o_avs_readdata;
    i_avs_write <= 1'b0;
    i_avs_read <= 1'b0;
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rc(input logic [3:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(q, e);
  endtask
  task automatic t_reset;
    rc(4'h0, 32'h0);
    rc(4'h4, 32'h0);
    wr(4'hc, 32'hffff_ffff);
    rc(4'hc, 32'h0);
  endtask
  task automatic t_ctrl;
    logic [31:0] d;
    wr(4'h0, 32'hffff_ffff);
    rc(4'h0, 32'h808f_ffff);
    for (int i = 0; i < 4; i++)
    begin
      d = {i[1], 7'h00, i[0], 23'h0};
      wr(4'h0, d);
      rc(4'h0, d);
      chk({31'h0, o_l2_ecc_check}, {31'h0, i[1] ^ i[0]});
    end
  endtask
  task automatic t_err;
    wr(4'h0, 32'h0);
    u_src.cerr(1);
    rc(4'h0, 32'h0008_0000);
    u_src.cerr(2);
    rc(4'h0, 32'h0018_0000);
    chk({31'h0, o_double_fault}, 32'h1);
    wr(4'h0, 32'h0);
    u_src.cerr(1);
    rc(4'h0, 32'h0008_0000);
    chk({31'h0, o_double_fault}, 32'h0);
  endtask
  task automatic t_ram;
    logic [63:0] d;
    logic [31:0] e;
    logic [3:0]  x;
    d = 64'h0123_4567_89ab_cdef;
    wr(4'h0, 32'h8000_0000);
    u_src.iread(6'h2d, d);
    e = {1'b1, 12'h000, 6'h2d, ^6'h2d, ep(d), 4'h0};
    rc(4'h0, e);
    chk({23'h0, o_icache_parity}, {23'h0, e[12:4]});
    // a wrong lane-0 parity must also raise a cache error
    u_src.dread(32'h1122_3380, 1'b1);
    x = 4'(ep({32'h0, 32'h1122_3380})) ^ 4'h1;
    rc(4'h0, {e[31:20], 1'b1, e[18:4], x});
    chk({28'h0, o_dcache_parity}, {28'h0, x});
  endtask
  task automatic t_bus;
    logic [31:0] q;
    for (int i = 0; i < 4; i++)
    begin
      u_src.berr(i[1], i[0]);
      bus(1'b0, 4'h0, 32'h0, q);
      chk({30'h0, q[25:24]}, {30'h0, i[1:0]});
    end
  endtask
  task automatic t_irq;
    wr(4'h0, 32'h0);
    wr(4'h4, 32'hf);
    wr(4'h8, 32'h0);
    u_src.cerr(1);
    rc(4'h4, 32'h1);
    chk({31'h0, o_irq}, 32'h0);
    wr(4'h8, 32'h1);
    rc(4'h8, 32'h1);
    chk({31'h0, o_irq}, 32'h1);
    wr(4'h4, 32'h1);
    rc(4'h4, 32'h0);
    chk({31'h0, o_irq}, 32'h0);
  endtask
  task automatic stop_test;
    $display("checks %0d errors %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (4) @(posedge i_clk_sys);
    i_srst <= 1'b0;
    t_reset();
    t_ctrl();
    t_err();
    t_ram();
    t_bus();
    t_irq();
    stop_test();
  end
  initial
  begin
    repeat (20000) @(posedge i_clk_sys);
    fail_count++;
    stop_test();
  end
endmodule
